// *** design/fps_pkg.sv ***
// Types of the flyback protection supervisor.
// Assumes nothing; constants live in fps_regs.svh.
package fps_pkg;
  typedef enum logic [3:0] {
    ST_START = 4'h1,
    ST_REG   = 4'h2,
    ST_WAIT  = 4'h4,
    ST_LATCH = 4'h8
  } fps_state_t;
endpackage

// *** design/fps_regs.svh ***
// Offsets, field positions, reset values and timing counts of the
// flyback protection supervisor. Definitions only; include by bare name.
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

// Register byte offsets, one aligned 32-bit word each
`define FPS_A_CTRL    8'h00
`define FPS_A_VLIM    8'h04
`define FPS_A_SLIM    8'h08
`define FPS_A_OCP     8'h0C
`define FPS_A_TIME    8'h10
`define FPS_A_STAT    8'h14
`define FPS_A_VIN     8'h18

// Control word fields
`define FPS_B_UVEN    0
`define FPS_B_UVLAT   1
`define FPS_B_OVLAT   2
`define FPS_B_ABMIN   3
`define FPS_F_GAIN    15:8
`define FPS_F_NBLK    23:16
`define FPS_F_QUAL    31:24

// Threshold and timer fields
`define FPS_F_LO12    11:0
`define FPS_F_HI12    27:16
`define FPS_F_OBLK    31:16
`define FPS_F_UBLK    23:0
`define FPS_F_CVCC    31:24

// Reset values
`define FPS_RST_CTRL  32'h0000_0000
`define FPS_RST_VLIM  32'h0FFF_0000
`define FPS_RST_SLIM  32'h0FFF_0000
`define FPS_RST_OCP   32'h0010_0000
`define FPS_RST_TIME  32'h0A00_FFFF

// Timing
`define FPS_CLK_MHZ   40
`define FPS_HP_NS     9823000
`define FPS_HP_CYC    (`FPS_HP_NS * `FPS_CLK_MHZ / 1000)
`define FPS_TST_K     967
`define FPS_TST_CYC   16'(`FPS_TST_K * `FPS_CLK_MHZ)
`define FPS_RST_WAIT  24'h009C40
`define FPS_SMP_SH    6
`define FPS_OV_SH     2
`define FPS_DM_SH     1

// Peak to rms scale, 181/256
`define FPS_RMS_NUM   9'h0B5

// Second overcurrent levels in mV
`define FPS_OCP_L0    12'h258
`define FPS_OCP_L1    12'h320
`define FPS_OCP_L2    12'h4B0
`define FPS_OCP_L3    12'h640

// AXI responses
`define FPS_OKAY      2'h0
`define FPS_SLVERR    2'h2
`endif

// *** design/fps_top.sv ***
// Flyback protection supervisor: input estimate, filter gating, faults.
// Assumes sense inputs already quantised and synchronous to ref_clk_i.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "fps_regs.svh"

module fps_top #(
  parameter logic [19:0] HP_PRESET_CYC = 20'(`FPS_HP_CYC),
  parameter logic [23:0] RESTART_CYC   = `FPS_RST_WAIT
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // AXI4-Lite slave
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] awaddr_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  output logic [1:0]       bresp_o,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  input  wire logic [31:0] araddr_i,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  // Power stage sense
  input  wire logic        gate_on_i,
  input  wire logic [11:0] zcd_clamp_current_i,
  input  wire logic [11:0] cs_peak_i,
  input  wire logic [11:0] cs_voltage_i,
  input  wire logic [11:0] vout_est_i,
  input  wire logic [11:0] iout_est_i,
  input  wire logic        demag_fail_i,
  input  wire logic        line_sync_i,
  input  wire logic        line_edge_i,
  // Operating mode and regulation
  input  wire logic        first_valley_mode_i,
  input  wire logic        discontinuous_mode_i,
  input  wire logic        burst_mode_i,
  input  wire logic        filtered_feedback_level_i,
  input  wire logic [7:0]  phase_i,
  input  wire logic [11:0] fb_ontime_i,
  // Results
  output logic             gate_enable_o,
  output logic [11:0]      ontime_o,
  output logic             notch_enable_o,
  output logic [7:0]       notch_quality_o,
  output logic             comp_active_o,
  output logic [11:0]      vin_rms_o,
  output logic [11:0]      ocp_level_o,
  output logic             vin_protect_active_o,
  output logic             fault_latched_o
);

  logic [31:0] ctrl_ff, vlim_ff, slim_ff, ocp_ff, time_ff;
  logic [4:0]  stat_ff;
  logic        aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic        awready_ff, wready_ff, arready_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  fps_pkg::fps_state_t state_ff, nxt_state;
  logic        gate_prev_ff, gate_en_ff, notch_ff, comp_ff;
  logic        vprot_ff, latched_ff;
  logic [19:0] ph_ff, hp_ff, slot_ff;
  logic [11:0] peak_ff, vin_ff, ocp_lvl_ff, ontime_ff;
  logic [7:0]  nb_cnt_ff;
  logic [23:0] st_cnt_ff, rs_cnt_ff;
  logic [23:0] cnt_ff [4];
  logic [23:0] lim [4];
  logic [3:0]  cond;
  logic [4:0]  trip;

  // Write channel: address and data taken in either order
  wire aw_hs  = awvalid_i & awready_ff;
  wire w_hs   = wvalid_i & wready_ff;
  wire wr_do  = (aw_got_ff | aw_hs) & (w_got_ff | w_hs);
  wire [7:0]  wa = aw_got_ff ? waddr_ff : awaddr_i[7:0];
  wire [31:0] wd = w_got_ff ? wdata_ff : wdata_i;
  wire [3:0]  ws = w_got_ff ? wstrb_ff : wstrb_i;
  wire [31:0] wm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire nxt_aw_got = (aw_got_ff | aw_hs) & ~wr_do;
  wire nxt_w_got  = (w_got_ff | w_hs) & ~wr_do;
  wire nxt_bvalid = wr_do | (bvalid_ff & ~bready_i);
  wire wr_hit = (wa == `FPS_A_CTRL) | (wa == `FPS_A_VLIM) |
                (wa == `FPS_A_SLIM) | (wa == `FPS_A_OCP)  |
                (wa == `FPS_A_TIME) | (wa == `FPS_A_STAT);
  wire [4:0] st_clr = (wr_do & (wa == `FPS_A_STAT) & ws[0]) ?
                      wd[4:0] : 5'h00;

  // Read channel and decode; higher address bits are not decoded
  wire ar_hs = arvalid_i & arready_ff;
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~rready_i);
  wire [7:0]  ra = araddr_i[7:0];
  wire [31:0] stat_rd = {17'h00000, gate_en_ff, comp_ff, notch_ff,
                         state_ff, 3'h0, stat_ff};
  wire [31:0] rd_val =
    (ra == `FPS_A_CTRL) ? ctrl_ff :
    (ra == `FPS_A_VLIM) ? vlim_ff :
    (ra == `FPS_A_SLIM) ? slim_ff :
    (ra == `FPS_A_OCP)  ? ocp_ff  :
    (ra == `FPS_A_TIME) ? time_ff :
    (ra == `FPS_A_STAT) ? stat_rd :
    (ra == `FPS_A_VIN)  ? {20'h00000, vin_ff} : 32'h0000_0000;
  wire rd_ok = (ra == `FPS_A_CTRL) | (ra == `FPS_A_VLIM) |
               (ra == `FPS_A_SLIM) | (ra == `FPS_A_OCP)  |
               (ra == `FPS_A_TIME) | (ra == `FPS_A_STAT) |
               (ra == `FPS_A_VIN);

  // Bus handshake state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bresp_ff   <= `FPS_OKAY;
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rresp_ff   <= `FPS_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      bvalid_ff  <= nxt_bvalid;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
      if (wr_do) bresp_ff <= wr_hit ? `FPS_OKAY : `FPS_SLVERR;
      rvalid_ff  <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_ok ? rd_val : 32'h0000_0000;
        rresp_ff <= rd_ok ? `FPS_OKAY : `FPS_SLVERR;
      end
    end
  end

  // Early halves of a write are held until the other half arrives
  always_ff @(posedge ref_clk_i) begin
    if (aw_hs) waddr_ff <= awaddr_i[7:0];
    if (w_hs) begin
      wdata_ff <= wdata_i;
      wstrb_ff <= wstrb_i;
    end
  end

  // Configuration registers with byte strobes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= `FPS_RST_CTRL;
      vlim_ff <= `FPS_RST_VLIM;
      slim_ff <= `FPS_RST_SLIM;
      ocp_ff  <= `FPS_RST_OCP;
      time_ff <= `FPS_RST_TIME;
    end else if (wr_do) begin
      if (wa == `FPS_A_CTRL) ctrl_ff <= (ctrl_ff & ~wm) | (wd & wm);
      if (wa == `FPS_A_VLIM) vlim_ff <= (vlim_ff & ~wm) | (wd & wm);
      if (wa == `FPS_A_SLIM) slim_ff <= (slim_ff & ~wm) | (wd & wm);
      if (wa == `FPS_A_OCP)  ocp_ff  <= (ocp_ff & ~wm) | (wd & wm);
      if (wa == `FPS_A_TIME) time_ff <= (time_ff & ~wm) | (wd & wm);
    end
  end

  // Half period timing; burst mode sleeps, so sync is ignored there
  wire sync_eff = line_sync_i & ~burst_mode_i;
  wire win_end  = sync_eff ? line_edge_i :
                  (ph_ff >= HP_PRESET_CYC - 20'h00001);
  wire gate_fall = gate_prev_ff & ~gate_on_i;
  wire smp_take  = gate_fall &
                   (slot_ff >= (hp_ff >> `FPS_SMP_SH));
  wire [12:0] est13 = {1'b0, zcd_clamp_current_i} + {1'b0, cs_peak_i};
  wire [11:0] est   = est13[12] ? 12'hFFF : est13[11:0];
  wire [11:0] pk_fin = (smp_take && est > peak_ff) ? est : peak_ff;
  wire [20:0] rms_p  = pk_fin * `FPS_RMS_NUM;

  // Sampling, peak tracking and rms refresh
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      gate_prev_ff <= 1'b0;
      ph_ff   <= 20'h00000;
      hp_ff   <= HP_PRESET_CYC;
      slot_ff <= 20'h00000;
      peak_ff <= 12'h000;
      vin_ff  <= 12'h000;
    end else begin
      gate_prev_ff <= gate_on_i;
      ph_ff   <= win_end ? 20'h00000 : ph_ff + 20'h00001;
      slot_ff <= smp_take ? 20'h00000 :
                 (&slot_ff ? slot_ff : slot_ff + 20'h00001);
      if (win_end) begin
        hp_ff   <= sync_eff ? ph_ff + 20'h00001 : HP_PRESET_CYC;
        peak_ff <= 12'h000;
        vin_ff  <= rms_p[19:8];
      end else begin
        peak_ff <= pk_fin;
      end
    end
  end

  // Notch gating and displacement compensation
  wire qd = (first_valley_mode_i | discontinuous_mode_i) & ~burst_mode_i;
  wire [7:0] gain = ctrl_ff[`FPS_F_GAIN];
  wire comp_on  = gain != 8'h00;
  wire comp_act = comp_on & filtered_feedback_level_i & qd;
  wire [15:0] gp = gain * phase_i;
  wire [12:0] vi = {1'b0, vin_ff} + {1'b0, iout_est_i};
  wire [12:0] dw = (vi > {1'b0, vout_est_i}) ?
                   vi - {1'b0, vout_est_i} : 13'h0000;
  wire [15:0] adj = gp[15:8] * dw[12:5];
  wire [12:0] ot13 = {1'b0, fb_ontime_i} + {1'b0, adj[15:4]};
  wire [11:0] ot_mod = ot13[12] ? 12'hFFF : ot13[11:0];

  // Second overcurrent level: lowest fixed level above the limit, else the highest one
  wire [11:0] ll = ocp_ff[`FPS_F_LO12];
  wire [11:0] lvl = (ll < `FPS_OCP_L0) ? `FPS_OCP_L0 :
                    (ll < `FPS_OCP_L1) ? `FPS_OCP_L1 :
                    (ll < `FPS_OCP_L2) ? `FPS_OCP_L2 :
                    `FPS_OCP_L3;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      nb_cnt_ff  <= 8'h00;
      notch_ff   <= 1'b0;
      comp_ff    <= 1'b0;
      ontime_ff  <= 12'h000;
      ocp_lvl_ff <= `FPS_OCP_L0;
      vprot_ff   <= 1'b0;
    end else begin
      if (!sync_eff) nb_cnt_ff <= 8'h00;
      else if (line_edge_i && !(&nb_cnt_ff)) nb_cnt_ff <= nb_cnt_ff + 8'h01;
      notch_ff  <= qd & sync_eff &
                   (nb_cnt_ff >= ctrl_ff[`FPS_F_NBLK]);
      comp_ff   <= comp_act;
      ontime_ff <= comp_act ? ot_mod : fb_ontime_i;
      ocp_lvl_ff <= lvl;
      vprot_ff  <= ~burst_mode_i | ctrl_ff[`FPS_B_ABMIN];
    end
  end

  // Blanking conditions; a fault needs its condition beyond the limit
  wire run = (state_ff == fps_pkg::ST_START) |
             (state_ff == fps_pkg::ST_REG);
  wire in_reg = state_ff == fps_pkg::ST_REG;
  assign cond[0] = run & (cs_voltage_i > ocp_lvl_ff);
  assign cond[1] = in_reg & ctrl_ff[`FPS_B_UVEN] & ~burst_mode_i &
                   (vout_est_i < vlim_ff[`FPS_F_LO12]);
  assign cond[2] = run & ~burst_mode_i &
                   (vout_est_i > vlim_ff[`FPS_F_HI12]);
  assign cond[3] = run & ~burst_mode_i & demag_fail_i;
  assign lim[0] = {8'h00, ocp_ff[`FPS_F_OBLK]};
  assign lim[1] = time_ff[`FPS_F_UBLK];
  assign lim[2] = {4'h0, hp_ff >> `FPS_OV_SH};
  assign lim[3] = {4'h0, hp_ff >> `FPS_DM_SH};

  // One saturating blank counter per monitored condition
  for (genvar i = 0; i < 4; i++) begin : g_blank
    assign trip[i] = cond[i] & (cnt_ff[i] >= lim[i]);
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i || !cond[i]) cnt_ff[i] <= 24'h000000;
      else if (!(&cnt_ff[i])) cnt_ff[i] <= cnt_ff[i] + 24'h000001;
    end
  end

  // Startup timeout scales with supply capacitance
  wire [23:0] tmax = time_ff[`FPS_F_CVCC] * `FPS_TST_CYC;
  wire st_on  = state_ff == fps_pkg::ST_START;
  wire tmax_hit = st_on & (st_cnt_ff >= tmax);
  assign trip[4] = tmax_hit &
                   (vout_est_i < slim_ff[`FPS_F_LO12]);
  wire st_done = st_on & ((vout_est_i >= slim_ff[`FPS_F_HI12]) |
                          tmax_hit);
  wire any_trip = |trip;
  wire lat_req = (trip[1] & ctrl_ff[`FPS_B_UVLAT]) |
                 (trip[2] & ctrl_ff[`FPS_B_OVLAT]);

  // Operating state; a latched fault waits for supply removal (reset)
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fps_pkg::ST_START: begin
        if (any_trip) nxt_state = lat_req ? fps_pkg::ST_LATCH
                                          : fps_pkg::ST_WAIT;
        else if (st_done) nxt_state = fps_pkg::ST_REG;
      end
      fps_pkg::ST_REG: begin
        if (any_trip) nxt_state = lat_req ? fps_pkg::ST_LATCH
                                          : fps_pkg::ST_WAIT;
      end
      fps_pkg::ST_WAIT: begin
        if (rs_cnt_ff >= RESTART_CYC) nxt_state = fps_pkg::ST_START;
      end
      fps_pkg::ST_LATCH: nxt_state = fps_pkg::ST_LATCH;
      default: nxt_state = fps_pkg::ST_START;
    endcase
  end

  // State, timers and sticky causes; a new event beats its clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_ff   <= fps_pkg::ST_START;
      st_cnt_ff  <= 24'h000000;
      rs_cnt_ff  <= 24'h000000;
      gate_en_ff <= 1'b0;
      latched_ff <= 1'b0;
      stat_ff    <= 5'h00;
    end else begin
      state_ff   <= nxt_state;
      st_cnt_ff  <= st_on ? st_cnt_ff + 24'h000001 : 24'h000000;
      rs_cnt_ff  <= (state_ff == fps_pkg::ST_WAIT) ?
                    rs_cnt_ff + 24'h000001 : 24'h000000;
      gate_en_ff <= (nxt_state == fps_pkg::ST_START) |
                    (nxt_state == fps_pkg::ST_REG);
      latched_ff <= nxt_state == fps_pkg::ST_LATCH;
      stat_ff    <= (stat_ff & ~st_clr) | trip;
    end
  end

  assign awready_o = awready_ff;
  assign wready_o  = wready_ff;
  assign bvalid_o  = bvalid_ff;
  assign bresp_o   = bresp_ff;
  assign arready_o = arready_ff;
  assign rvalid_o  = rvalid_ff;
  assign rdata_o   = rdata_ff;
  assign rresp_o   = rresp_ff;
  assign gate_enable_o   = gate_en_ff;
  assign ontime_o        = ontime_ff;
  assign notch_enable_o  = notch_ff;
  assign notch_quality_o = ctrl_ff[`FPS_F_QUAL];
  assign comp_active_o   = comp_ff;
  assign vin_rms_o       = vin_ff;
  assign ocp_level_o     = ocp_lvl_ff;
  assign vin_protect_active_o = vprot_ff;
  assign fault_latched_o = latched_ff;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_fault; any_trip && run; endsequence
  sequence s_off; !gate_en_ff ##1 !gate_en_ff; endsequence

  smp_spacing_a: assert property (smp_take |->
    slot_ff >= (hp_ff >> 6)) else $error("sample too early");
  smp_edge_a: assert property (smp_take |->
    $past(gate_on_i) && !gate_on_i) else $error("sample off edge");
  preset_win_a: assert property (!sync_eff && win_end |=>
    hp_ff == HP_PRESET_CYC) else $error("preset period lost");
  rms_val_a: assert property (win_end |=>
    vin_ff == 12'(($past(pk_fin) * 181) >> 8)) else $error("rms wrong");
  rms_once_a: assert property ($changed(vin_ff) |->
    $past(win_end)) else $error("rms off window");
  notch_mode_a: assert property (notch_ff |->
    $past(qd && sync_eff)) else $error("notch out of mode");
  comp_zero_a: assert property (gain == 8'h00 |=> !comp_ff)
    else $error("comp with zero gain");
  ocp_lvl_a: assert property (##1 ocp_lvl_ff > $past(ll) ||
    ocp_lvl_ff == 12'h640) else $error("bad ocp level");
  burst_quiet_a: assert property (burst_mode_i |->
    !trip[1] && !trip[2] && !trip[3]) else $error("burst fault");
  fault_off_a: assert property (s_fault |=> s_off)
    else $error("gate on after fault");
  latch_hold_a: assert property (latched_ff |=> latched_ff)
    else $error("latch released");
endmodule

// *** testbench/flyback_protection_supervisor_bench.sv ***
// Bench for the flyback protection supervisor: bus, estimate, faults.
// Assumes fps_top with short periods and the fps_stage model.
`timescale 1ns/1ps
`include "fps_regs.svh"
module flyback_protection_supervisor_bench;
  // Bus side
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
  logic        arvalid_i = 1'b0, rready_i = 1'b0;
  logic [31:0] awaddr_i = 32'h0, wdata_i = 32'h0, araddr_i = 32'h0;
  logic [3:0]  wstrb_i = 4'hF;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0]  bresp_o, rresp_o, rs;
  logic [31:0] rdata_o, rd;
  // Sense and mode side
  logic        gate_on_i, line_sync_i, line_edge_i, sync_en = 1'b0;
  logic        demag_fail_i = 1'b0, burst_mode_i = 1'b0;
  logic        first_valley_mode_i = 1'b1, discontinuous_mode_i = 1'b0;
  logic        filtered_feedback_level_i = 1'b1;
  logic [11:0] zcd_clamp_current_i, clamp_lvl = 12'h0, cs_peak_i = 12'h0;
  logic [11:0] cs_voltage_i = 12'h0, vout_est_i = 12'h1F4;
  logic [11:0] iout_est_i = 12'h0, fb_ontime_i = 12'h123;
  logic [7:0]  phase_i = 8'h40, notch_quality_o;
  logic        gate_enable_o, notch_enable_o, comp_active_o;
  logic        vin_protect_active_o, fault_latched_o;
  logic [11:0] ontime_o, vin_rms_o, ocp_level_o;
  int          bad_count = 0, tests_run = 0;
  // Low-line limits and the second overcurrent level each must pick
  logic [11:0] lim [7] = '{12'h000, 12'h258, 12'h2BC, 12'h320, 12'h4B0,
                           12'h63F, 12'h640};
  logic [11:0] lvl [7] = '{12'h258, 12'h320, 12'h320, 12'h4B0, 12'h640,
                           12'h640, 12'h640};

  // 40 MHz reference clock
  always #12.5 ref_clk_i = ~ref_clk_i;

  // Short half period and restart wait keep the run brief
  fps_top #(.HP_PRESET_CYC(20'h000C8), .RESTART_CYC(24'h000014)) u_fps_top (
    .ref_clk_i, .rst_b_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i,
    .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o,
    .arvalid_i, .arready_o, .araddr_i, .rvalid_o, .rready_i, .rdata_o,
    .rresp_o, .gate_on_i, .zcd_clamp_current_i, .cs_peak_i, .cs_voltage_i,
    .vout_est_i, .iout_est_i, .demag_fail_i, .line_sync_i, .line_edge_i,
    .first_valley_mode_i, .discontinuous_mode_i, .burst_mode_i,
    .filtered_feedback_level_i, .phase_i, .fb_ontime_i, .gate_enable_o,
    .ontime_o, .notch_enable_o, .notch_quality_o, .comp_active_o,
    .vin_rms_o, .ocp_level_o, .vin_protect_active_o, .fault_latched_o);

  fps_stage #(.LINE_CYC(160)) u_fps_stage (
    .ref_clk_i, .rst_b_i, .gate_enable_i(gate_enable_o), .sync_en_i(sync_en),
    .clamp_lvl_i(clamp_lvl), .gate_on_o(gate_on_i),
    .clamp_o(zcd_clamp_current_i), .line_sync_o(line_sync_i),
    .line_edge_o(line_edge_i));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // A wait that ran out is a mismatch and ends the run
  task automatic hang();
    bad_count++;
    $display("[FAIL] handshake expected answer seen none");
    summarize();
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr_i <= {24'h000000, a};
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge ref_clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) begin
        bready_i <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp_o));
        @(posedge ref_clk_i);
        return;
      end
    end
    hang();
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] er);
    araddr_i <= {24'h000000, a};
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge ref_clk_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) begin
        rready_i <= 1'b0;
        rd = rdata_o;
        rs = rresp_o;
        chk("rdata", e, rd & m);
        chk("rresp", 32'(er), 32'(rs));
        @(posedge ref_clk_i);
        return;
      end
    end
    hang();
  endtask

  task automatic rst_cycle();
    rst_b_i <= 1'b0;
    cyc(4);
    rst_b_i <= 1'b1;
    cyc(2);
  endtask

  task automatic gate(input logic e);
    chk("gate_enable", 32'(e), 32'(gate_enable_o));
  endtask

  // Main sequence
  initial begin
    rst_cycle();
    rchk(`FPS_A_CTRL, 32'hFFFFFFFF, `FPS_RST_CTRL, `FPS_OKAY);
    rchk(`FPS_A_VLIM, 32'hFFFFFFFF, `FPS_RST_VLIM, `FPS_OKAY);
    rchk(`FPS_A_SLIM, 32'hFFFFFFFF, `FPS_RST_SLIM, `FPS_OKAY);
    rchk(`FPS_A_OCP, 32'hFFFFFFFF, `FPS_RST_OCP, `FPS_OKAY);
    rchk(`FPS_A_TIME, 32'hFFFFFFFF, `FPS_RST_TIME, `FPS_OKAY);
    rchk(8'h1C, 32'hFFFFFFFF, 32'h0, `FPS_SLVERR);
    wr(`FPS_A_VIN, 32'h1, `FPS_SLVERR);
    wr(`FPS_A_SLIM, 32'h0064_0032, `FPS_OKAY);
    wr(`FPS_A_VLIM, 32'h0800_0100, `FPS_OKAY);
    burst_mode_i <= 1'b1;
    cyc(3);
    chk("vin_protect", 32'h0, 32'(vin_protect_active_o));
    wr(`FPS_A_CTRL, 32'h0000_0008, `FPS_OKAY);
    cyc(2);
    chk("vin_protect", 32'h1, 32'(vin_protect_active_o));
    burst_mode_i <= 1'b0;
    wr(`FPS_A_CTRL, 32'h0, `FPS_OKAY);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(`FPS_A_OCP, {16'h0010, 4'h0, lim[i]}, `FPS_OKAY);
      cyc(2);
      chk("ocp_level", 32'(lvl[i]), 32'(ocp_level_o));
    end
    $display("test level select done");
    clamp_lvl <= 12'h3E8;
    cs_peak_i <= 12'h0C8;
    cyc(450);
    chk("vin_rms", 32'h350, 32'(vin_rms_o));
    clamp_lvl <= 12'h190;
    cs_peak_i <= 12'h000;
    cyc(450);
    chk("vin_rms", 32'h11A, 32'(vin_rms_o));
    rchk(`FPS_A_VIN, 32'h0000_0FFF, 32'h11A, `FPS_OKAY);
    $display("test input estimate done");
    iout_est_i <= 12'h400;
    cyc(3);
    chk("comp_active", 32'h0, 32'(comp_active_o));
    chk("ontime", 32'h123, 32'(ontime_o));
    wstrb_i <= 4'h2;
    wr(`FPS_A_CTRL, 32'hFFFF_40FF, `FPS_OKAY);
    wstrb_i <= 4'hF;
    cyc(3);
    chk("comp_active", 32'h1, 32'(comp_active_o));
    chk("ontime", 32'h13C, 32'(ontime_o));
    first_valley_mode_i <= 1'b0;
    discontinuous_mode_i <= 1'b1;
    cyc(3);
    chk("ontime", 32'h13C, 32'(ontime_o));
    discontinuous_mode_i <= 1'b0;
    cyc(3);
    chk("ontime", 32'h123, 32'(ontime_o));
    first_valley_mode_i <= 1'b1;
    filtered_feedback_level_i <= 1'b0;
    cyc(3);
    chk("ontime", 32'h123, 32'(ontime_o));
    filtered_feedback_level_i <= 1'b1;
    $display("test compensation done");
    wr(`FPS_A_CTRL, 32'h5A02_0000, `FPS_OKAY);
    sync_en <= 1'b1;
    cyc(10);
    chk("notch", 32'h0, 32'(notch_enable_o));
    chk("notch_q", 32'h5A, 32'(notch_quality_o));
    cyc(400);
    chk("notch", 32'h1, 32'(notch_enable_o));
    first_valley_mode_i <= 1'b0;
    cyc(3);
    chk("notch", 32'h0, 32'(notch_enable_o));
    first_valley_mode_i <= 1'b1;
    $display("test notch done");
    vout_est_i <= 12'h900;
    cyc(36);
    gate(1'b1);
    cyc(10);
    gate(1'b0);
    vout_est_i <= 12'h1F4;
    cyc(30);
    gate(1'b1);
    sync_en <= 1'b0;
    wr(`FPS_A_OCP, 32'h000A_02BC, `FPS_OKAY);
    cs_voltage_i <= 12'h384;
    cyc(8);
    gate(1'b1);
    cyc(6);
    gate(1'b0);
    cs_voltage_i <= 12'h000;
    cyc(30);
    gate(1'b1);
    rchk(`FPS_A_STAT, 32'h1F, 32'h05, `FPS_OKAY);
    wr(`FPS_A_STAT, 32'h1F, `FPS_OKAY);
    // The measured half period of 160 still holds, so the limit is 80
    demag_fail_i <= 1'b1;
    cyc(75);
    gate(1'b1);
    cyc(15);
    gate(1'b0);
    demag_fail_i <= 1'b0;
    cyc(50);
    rchk(`FPS_A_STAT, 32'h1F, 32'h08, `FPS_OKAY);
    burst_mode_i <= 1'b1;
    vout_est_i <= 12'h900;
    demag_fail_i <= 1'b1;
    cyc(250);
    gate(1'b1);
    vout_est_i <= 12'h050;
    demag_fail_i <= 1'b0;
    wr(`FPS_A_CTRL, 32'h0000_0003, `FPS_OKAY);
    wr(`FPS_A_TIME, 32'h0A00_000A, `FPS_OKAY);
    cyc(50);
    gate(1'b1);
    burst_mode_i <= 1'b0;
    cyc(8);
    gate(1'b1);
    cyc(10);
    gate(1'b0);
    cyc(40);
    gate(1'b0);
    chk("latched", 32'h1, 32'(fault_latched_o));
    $display("test faults done");
    vout_est_i <= 12'h1F4;
    rst_cycle();
    wr(`FPS_A_SLIM, 32'h0FFF_0300, `FPS_OKAY);
    wr(`FPS_A_TIME, 32'h0100_FFFF, `FPS_OKAY);
    cyc(38540);
    rchk(`FPS_A_STAT, 32'h10, 32'h00, `FPS_OKAY);
    cyc(200);
    rchk(`FPS_A_STAT, 32'h10, 32'h10, `FPS_OKAY);
    $display("test startup done");
    // Overvoltage with its latch selected; preset period gives a limit of 50
    wr(`FPS_A_VLIM, 32'h0800_0100, `FPS_OKAY);
    wr(`FPS_A_CTRL, 32'h0000_0004, `FPS_OKAY);
    vout_est_i <= 12'h900;
    cyc(70);
    gate(1'b0);
    chk("latched", 32'h1, 32'(fault_latched_o));
    $display("test overvoltage latch done");
    summarize();
  end
endmodule

// *** testbench/fps_stage.sv ***
// Power stage model: switch pulses, clamp current and line edges.
// Assumes the bench sets the clamp level and whether the line is synced.
`timescale 1ns/1ps
module fps_stage #(
  parameter int LINE_CYC = 160
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Control from bench and controller
  input  wire logic        gate_enable_i,
  input  wire logic        sync_en_i,
  input  wire logic [11:0] clamp_lvl_i,
  // Sense pins
  output logic             gate_on_o,
  output logic [11:0]      clamp_o,
  output logic             line_sync_o,
  output logic             line_edge_o
);
  logic [2:0] sw_ff;
  logic [7:0] ln_ff;

  // Switch period of 8 cycles, line period of LINE_CYC cycles
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sw_ff <= 3'h0;
      ln_ff <= 8'h00;
    end else begin
      sw_ff <= sw_ff + 3'h1;
      ln_ff <= (ln_ff == 8'(LINE_CYC - 1)) ? 8'h00 : ln_ff + 8'h01;
    end
  end

  // Switch conducts only while the controller enables the gate
  assign gate_on_o = gate_enable_i && (sw_ff < 3'h3);
  // Clamp settles only as the on-time ends, so any earlier sample reads
  // full scale; after that slot the current is meaningless and inverted
  assign clamp_o = (sw_ff < 3'h3)  ? 12'hFFF :
                   (sw_ff == 3'h3) ? clamp_lvl_i : ~clamp_lvl_i;
  assign line_sync_o = sync_en_i;
  assign line_edge_o = sync_en_i && (ln_ff == 8'h00);
endmodule
